//--- hdl/pf_pkg.sv
/*
 pf_pkg: register map, field positions and reset values of the port-one
 pin function select block.
 assumes: APB3 slave, 32-bit data, one word per register.
*/
package pf_pkg;
   // register byte offsets
   localparam logic [7:0] PF_OFS_DATA = 8'h00;
   localparam logic [7:0] PF_OFS_DIR = 8'h04;
   localparam logic [7:0] PF_OFS_PULLUP = 8'h08;
   localparam logic [7:0] PF_OFS_FUNC = 8'h0C;
   localparam logic [7:0] PF_OFS_EDGE = 8'h10;

   // reset values
   localparam logic [7:0] PF_RST_DATA = 8'h00;
   localparam logic [7:0] PF_RST_DIR = 8'h00;
   localparam logic [7:0] PF_RST_PULLUP = 8'h00;
   localparam logic [7:0] PF_RST_FUNC = 8'h00;
   localparam logic [2:0] PF_RST_EDGE = 3'h0;

   // function select bit positions
   localparam int PF_BIT_EXT_INT_THREE = 7;
   localparam int PF_BIT_EXT_INT_TWO = 6;
   localparam int PF_BIT_EXT_INT_ONE = 5;
   localparam int PF_BIT_PWM = 4;
   localparam int PF_BIT_TIMER_G_CAPTURE = 3;
   localparam int PF_BIT_TIMER_F_HIGH = 2;
   localparam int PF_BIT_TIMER_F_LOW = 1;
   localparam int PF_BIT_TIMER_A_CLOCK = 0;

   // edge select bits, one per shared input on pins 5, 6, 7 (1 = rising)
   localparam int PF_EDGE_PIN_FIRST = 5;
   localparam int PF_EDGE_COUNT = 3;

   // pins whose alternate function drives the pin
   localparam logic [7:0] PF_ALT_OUT_MASK = 8'h17;

   // timer clock-select codes that open the event inputs
   localparam logic [2:0] PF_TC_SEL_EXT = 3'h7;
   localparam int PF_TF_SEL_MSB = 2;

   // direction register reads back as all ones
   localparam logic [31:0] PF_DIR_READ = 32'h0000_00FF;
endpackage

//--- hdl/pf_pin_cell.sv
/*
 pf_pin_cell: one port pin; picks general I/O or alternate function,
 drives the pin, controls the pull-up and forms the read-back bit.
 assumes: pin_in synchronous to pclk; pad resolves the wire from pin_oe.
*/
`timescale 1ns/1ps
module pf_pin_cell
   import pf_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic mode_sel,
   input wire logic dir_bit,
   input wire logic latch_bit,
   input wire logic alt_drive,
   input wire logic alt_value,
   input wire logic pullup_bit,
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe,
   output logic pullup_on,
   output logic read_bit
);
   logic pin_out_ff;
   logic pin_oe_ff;
   logic pullup_ff;
   logic nxt_pin_out;
   logic nxt_pin_oe;
   logic nxt_pullup;

   always_comb begin
      nxt_pin_oe = mode_sel ? alt_drive : dir_bit; // R16 R19
      nxt_pin_out = mode_sel ? (alt_drive & alt_value) : latch_bit; // R16
      nxt_pullup = pullup_bit & ~nxt_pin_oe; // R01 R02 R22
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out_ff <= 1'b0;
         pin_oe_ff <= 1'b0;
         pullup_ff <= 1'b0;
      end else begin
         pin_out_ff <= nxt_pin_out;
         pin_oe_ff <= nxt_pin_oe;
         pullup_ff <= nxt_pullup;
      end
   end

   // latch for general outputs, live level otherwise
   assign read_bit = (!mode_sel && dir_bit) ? latch_bit : pin_in; // R20
   assign pin_out = pin_out_ff;
   assign pin_oe = pin_oe_ff;
   assign pullup_on = pullup_ff;
endmodule

//--- hdl/pf_port_one.sv
/*
 pf_port_one: port-one pin function select with APB3 register access,
 eight pin cells, edge sensing for the shared interrupt/timer inputs.
 assumes: pins and timer signals synchronous to pclk; timers supply
 their clock-select fields; interrupt enables live in the interrupt unit.
*/
// Operation
// (R01) pull-up bit one turns input pull-up on
// (R02) pull-up bit zero turns input pull-up off
// (R03) pull-up register read/write, reset to zero
// (R04) function register read/write, reset to zero
// (R05) bit 7 selects interrupt three, timer F
// (R06) bit 6 selects interrupt two, timer C
// (R07) bit 5 selects interrupt one, timer B
// (R08) bit 4 drives pin from PWM
// (R09) bit 3 routes pin to timer G capture
// (R10) bit 2 drives timer F high output
// (R11) bit 1 drives timer F low output
// (R12) bit 0 drives timer A clock output
// (R13) shared inputs sense rising or falling edge
// (R14) timer F event only when select 0**
// (R15) timer C event only when select 111
// (R16) direction used only in general I/O
// (R17) software disables interrupt three for timer F
// (R18) software disables interrupt two for timer C
// (R19) direction one output, zero input
// (R20) data read: latch for outputs, pin otherwise
// (R21) direction register reads all ones
// (R22) pull-up off while pin is output
`timescale 1ns/1ps
module pf_port_one
   import pf_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   output logic [7:0] pullup_on,
   input wire logic pwm_out,
   input wire logic timer_f_high_out,
   input wire logic timer_f_low_out,
   input wire logic timer_a_clock_out,
   input wire logic [2:0] timer_f_clock_select,
   input wire logic [2:0] timer_c_clock_select,
   output logic ext_int_one_req,
   output logic ext_int_two_req,
   output logic ext_int_three_req,
   output logic timer_b_event_in,
   output logic timer_c_event_in,
   output logic timer_f_event_in,
   output logic timer_g_capture_in
);
   if (ADDR_W < 5 || ADDR_W > 32) begin : g_addr_check
      $error("pf_port_one: ADDR_W must lie in 5..32");
   end

   logic [7:0] data_latch_ff;
   logic [7:0] direction_ff;
   logic [7:0] pullup_ff;
   logic [7:0] func_sel_ff;
   logic [2:0] edge_sel_ff;
   logic [31:0] prdata_ff;
   logic [2:0] prev_pin_ff;
   logic [2:0] ext_req_ff;
   logic timer_b_ev_ff;
   logic timer_c_ev_ff;
   logic timer_f_ev_ff;
   logic capture_ff;
   logic [7:0] port_read;
   logic [7:0] alt_value;
   logic [7:0] pin_is_out;
   logic [2:0] edge_hit;
   logic [7:0] addr_lo;
   logic addr_hit;
   logic setup_rd;
   logic wr_en;
   logic [31:0] rd_value;

   // bus decode; zero wait states
   assign addr_lo = 8'(paddr);
   // address bits above the map must be zero
   assign addr_hit = (ADDR_W <= 8 || (paddr >> 8) == ADDR_W'(0)) &&
                     (addr_lo == PF_OFS_DATA || addr_lo == PF_OFS_DIR || addr_lo == PF_OFS_PULLUP ||
                      addr_lo == PF_OFS_FUNC || addr_lo == PF_OFS_EDGE);
   assign setup_rd = psel && !penable && !pwrite;
   assign wr_en = psel && penable && pwrite && addr_hit;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_hit;

   // register writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_latch_ff <= PF_RST_DATA;
      end else if (wr_en && addr_lo == PF_OFS_DATA) begin
         data_latch_ff <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         direction_ff <= PF_RST_DIR;
      end else if (wr_en && addr_lo == PF_OFS_DIR) begin
         direction_ff <= pwdata[7:0]; // R19
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pullup_ff <= PF_RST_PULLUP; // R03
      end else if (wr_en && addr_lo == PF_OFS_PULLUP) begin
         pullup_ff <= pwdata[7:0]; // R03
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         func_sel_ff <= PF_RST_FUNC; // R04
      end else if (wr_en && addr_lo == PF_OFS_FUNC) begin
         func_sel_ff <= pwdata[7:0]; // R04
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_sel_ff <= PF_RST_EDGE;
      end else if (wr_en && addr_lo == PF_OFS_EDGE) begin
         edge_sel_ff <= pwdata[2:0]; // R13
      end
   end

   // read data captured in the setup phase
   always_comb begin
      rd_value = 32'h0000_0000;
      if (addr_hit) begin
         case (addr_lo)
            PF_OFS_DATA: rd_value = {24'h00_0000, port_read}; // R20
            PF_OFS_DIR: rd_value = PF_DIR_READ; // R21
            PF_OFS_PULLUP: rd_value = {24'h00_0000, pullup_ff};
            PF_OFS_FUNC: rd_value = {24'h00_0000, func_sel_ff};
            PF_OFS_EDGE: rd_value = {29'h0000_0000, edge_sel_ff};
            default: rd_value = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (setup_rd) begin
         prdata_ff <= rd_value;
      end
   end
   assign prdata = prdata_ff;

   // alternate output sources per pin
   assign alt_value = {3'h0, pwm_out, 1'b0, timer_f_high_out, timer_f_low_out, timer_a_clock_out}; // R08 R10 R11 R12
   assign pin_is_out = (func_sel_ff & PF_ALT_OUT_MASK) | (~func_sel_ff & direction_ff);

   for (genvar i = 0; i < 8; i++) begin : g_pin
      pf_pin_cell u_cell (
         .pclk(pclk),
         .presetn(presetn),
         .mode_sel(func_sel_ff[i]),
         .dir_bit(direction_ff[i]),
         .latch_bit(data_latch_ff[i]),
         .alt_drive(PF_ALT_OUT_MASK[i]),
         .alt_value(alt_value[i]),
         .pullup_bit(pullup_ff[i]),
         .pin_in(pin_in[i]),
         .pin_out(pin_out[i]),
         .pin_oe(pin_oe[i]),
         .pullup_on(pullup_on[i]),
         .read_bit(port_read[i])
      );
   end

   // edge sensing on shared inputs, pins 5..7
   for (genvar e = 0; e < PF_EDGE_COUNT; e++) begin : g_edge
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            prev_pin_ff[e] <= 1'b0;
         end else begin
            prev_pin_ff[e] <= pin_in[PF_EDGE_PIN_FIRST+e];
         end
      end
      assign edge_hit[e] = func_sel_ff[PF_EDGE_PIN_FIRST+e] &&
                           (edge_sel_ff[e] ? (pin_in[PF_EDGE_PIN_FIRST+e] && !prev_pin_ff[e])
                                           : (!pin_in[PF_EDGE_PIN_FIRST+e] && prev_pin_ff[e])); // R13
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_req_ff <= 3'h0;
      end else begin
         ext_req_ff <= edge_hit; // R05 R06 R07
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_b_ev_ff <= 1'b0;
         timer_c_ev_ff <= 1'b0;
         timer_f_ev_ff <= 1'b0;
      end else begin
         timer_b_ev_ff <= edge_hit[0]; // R07
         timer_c_ev_ff <= edge_hit[1] && (timer_c_clock_select == PF_TC_SEL_EXT); // R15
         timer_f_ev_ff <= edge_hit[2] && !timer_f_clock_select[PF_TF_SEL_MSB]; // R14
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_ff <= 1'b0;
      end else begin
         capture_ff <= func_sel_ff[PF_BIT_TIMER_G_CAPTURE] & pin_in[PF_BIT_TIMER_G_CAPTURE]; // R09
      end
   end

   // interrupt enables are the interrupt unit's concern
   assign ext_int_one_req = ext_req_ff[0];
   assign ext_int_two_req = ext_req_ff[1]; // R18
   assign ext_int_three_req = ext_req_ff[2]; // R17
   assign timer_b_event_in = timer_b_ev_ff;
   assign timer_c_event_in = timer_c_ev_ff;
   assign timer_f_event_in = timer_f_ev_ff;
   assign timer_g_capture_in = capture_ff;

   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_pullup_follow: assert property ( // R01 R02 R22
      ##1 pullup_on == $past(pullup_ff & ~pin_is_out))
      else $error("pull-up does not follow control and direction");

   a_regs_after_reset: assert property ( // R03 R04
      $rose(presetn) |-> pullup_ff == PF_RST_PULLUP && func_sel_ff == PF_RST_FUNC)
      else $error("registers not cleared by reset");

   a_reg_write_back: assert property ( // R03
      wr_en && addr_lo == PF_OFS_PULLUP |=> pullup_ff == $past(pwdata[7:0]))
      else $error("pull-up register write lost");

   a_dir_controls_oe: assert property ( // R16 R19
      ##1 pin_oe == $past(pin_is_out))
      else $error("pin enable does not follow mode and direction");

   a_int_three_src: assert property ( // R05
      ext_int_three_req |-> $past(func_sel_ff[PF_BIT_EXT_INT_THREE]))
      else $error("interrupt three without mode bit");

   a_timer_f_gate: assert property ( // R14
      timer_f_event_in |-> ext_int_three_req && !$past(timer_f_clock_select[PF_TF_SEL_MSB]))
      else $error("timer F event while clock select not 0**");

   a_timer_c_gate: assert property ( // R06 R15
      timer_c_event_in |-> ext_int_two_req && $past(timer_c_clock_select) == PF_TC_SEL_EXT)
      else $error("timer C event while clock select not 111");

   a_timer_b_pair: assert property ( // R07
      timer_b_event_in == ext_int_one_req)
      else $error("timer B event differs from interrupt one");

   a_rising_edge: assert property ( // R13
      func_sel_ff[PF_BIT_EXT_INT_THREE] && edge_sel_ff[2] && pin_in[7] && !$past(pin_in[7])
      |=> ext_int_three_req)
      else $error("rising edge on pin 7 not sensed");

   a_pwm_route: assert property ( // R08
      func_sel_ff[PF_BIT_PWM] |=> pin_oe[4] && pin_out[4] == $past(pwm_out))
      else $error("pin 4 not driven from PWM");

   a_capture_route: assert property ( // R09
      ##1 timer_g_capture_in == $past(func_sel_ff[3] & pin_in[3]))
      else $error("timer G capture input wrong");

   a_timer_f_outs: assert property ( // R10 R11
      func_sel_ff[2] && func_sel_ff[1] |=> pin_out[2:1] == $past({timer_f_high_out, timer_f_low_out}))
      else $error("timer F outputs not on pins 2 and 1");

   a_clock_out: assert property ( // R12
      func_sel_ff[0] |=> pin_oe[0] && pin_out[0] == $past(timer_a_clock_out))
      else $error("pin 0 not driven from timer A clock");

   a_data_read: assert property ( // R20
      setup_rd && addr_lo == PF_OFS_DATA && addr_hit |=> prdata[7:0] ==
      $past((direction_ff & ~func_sel_ff & data_latch_ff) | (~(direction_ff & ~func_sel_ff) & pin_in)))
      else $error("port data read wrong");

   a_dir_read_ones: assert property ( // R21
      setup_rd && addr_lo == PF_OFS_DIR && addr_hit |=> prdata == PF_DIR_READ)
      else $error("direction register not read as ones");

   a_fall_edge: assert property ( // R13
      func_sel_ff[PF_BIT_EXT_INT_ONE] && !edge_sel_ff[0] && !pin_in[5] && $past(pin_in[5])
      |=> ext_int_one_req)
      else $error("falling edge on pin 5 not sensed");

   a_timer_f_open: assert property ( // R14
      ext_int_three_req && !$past(timer_f_clock_select[PF_TF_SEL_MSB]) |-> timer_f_event_in)
      else $error("timer F event missing while clock select 0**");

   a_timer_c_open: assert property ( // R15
      ext_int_two_req && $past(timer_c_clock_select) == PF_TC_SEL_EXT |-> timer_c_event_in)
      else $error("timer C event missing while clock select 111");

   a_gpio_no_req: assert property ( // R05 R06 R07
      func_sel_ff[7:5] == 3'h0 |=> {ext_int_three_req, ext_int_two_req, ext_int_one_req} == 3'h0)
      else $error("interrupt request from a general I/O pin");

   a_func_write: assert property ( // R04
      wr_en && addr_lo == PF_OFS_FUNC |=> func_sel_ff == $past(pwdata[7:0]))
      else $error("function register write lost");

   a_edge_write: assert property ( // R13
      wr_en && addr_lo == PF_OFS_EDGE |=> edge_sel_ff == $past(pwdata[2:0]))
      else $error("edge select register write lost");

   a_no_pullup_drive: assert property ( // R22
      (pullup_on & pin_oe) == 8'h00)
      else $error("pull-up on while pin drives");

   a_capture_undriven: assert property ( // R09 R16
      func_sel_ff[PF_BIT_TIMER_G_CAPTURE] |=> !pin_oe[PF_BIT_TIMER_G_CAPTURE])
      else $error("capture pin driven in alternate mode");

   c_pwm_mode: cover property (func_sel_ff[PF_BIT_PWM] ##1 pin_oe[4]);
   c_timer_f_event: cover property (timer_f_event_in);
   c_timer_c_event: cover property (timer_c_event_in);
   c_unmapped: cover property (pslverr);
   c_fall_edge: cover property (func_sel_ff[PF_BIT_EXT_INT_ONE] && !edge_sel_ff[0] ##1 ext_int_one_req);
endmodule

//--- sim/pf_board.sv
/*
 pf_board: board side of port one; resolves each pad from the port drive,
 an external driver, the pull-up, and a weak pull-down otherwise.
 assumes: the bench drives ext_drv only where the port does not drive.
*/
`timescale 1ns/1ps
module pf_board (
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] pullup_on,
   input wire logic [7:0] ext_drv,
   input wire logic [7:0] ext_val,
   output logic [7:0] pin_in
);
   // port drive wins, then external driver, then pull-up
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe[i]) pin_in[i] = pin_out[i];
         else if (ext_drv[i]) pin_in[i] = ext_val[i];
         else pin_in[i] = pullup_on[i];
      end
   end
endmodule

//--- sim/port_one_pin_function_select_bench.sv
/*
 port_one_pin_function_select_bench: self-checking bench of pf_port_one.
 assumes: zero-wait APB slave, board model pf_board, timer sources driven here.
*/
`timescale 1ns/1ps
module port_one_pin_function_select_bench;
   import pf_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] pin_in, pin_out, pin_oe, pullup_on, ext_drv, ext_val;
   logic pwm_out, tf_high, tf_low, ta_clk, int1, int2, int3, tb_ev, tc_ev, tf_ev, tg_cap;
   logic [2:0] tf_sel, tc_sel;
   logic [5:0] seen;
   logic [1:0] irq_seen;
   logic int_two_enable, int_three_enable;
   int n_fail, n_tests, cyc;

   pf_port_one #(.ADDR_W(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
      .pwm_out(pwm_out), .timer_f_high_out(tf_high), .timer_f_low_out(tf_low),
      .timer_a_clock_out(ta_clk), .timer_f_clock_select(tf_sel), .timer_c_clock_select(tc_sel),
      .ext_int_one_req(int1), .ext_int_two_req(int2), .ext_int_three_req(int3),
      .timer_b_event_in(tb_ev), .timer_c_event_in(tc_ev), .timer_f_event_in(tf_ev),
      .timer_g_capture_in(tg_cap));
   pf_board board (.pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on), .ext_drv(ext_drv),
      .ext_val(ext_val), .pin_in(pin_in));

   always #2 pclk = ~pclk;

   task close_out;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         close_out;
      end
   end

   task check(input string what, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task settle;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
   endtask

   // collect event and request pulses after one pin change
   task pulses(input logic [7:0] v);
      @(posedge pclk);
      ext_val <= v;
      seen = 6'h00;
      irq_seen = 2'h0;
      repeat (5) begin
         @(negedge pclk);
         seen = seen | {int3, int2, int1, tf_ev, tc_ev, tb_ev};
         irq_seen = irq_seen | {int3 & int_three_enable, int2 & int_two_enable};
      end
   endtask

   task t_regs;
      apb(0, PF_OFS_PULLUP, 0);
      check("pullup reset", rd, 32'h0000_0000);
      apb(0, PF_OFS_FUNC, 0);
      check("func reset", rd, 32'h0000_0000);
      apb(0, PF_OFS_DIR, 0);
      check("dir read", rd, 32'h0000_00FF);
      apb(1, PF_OFS_PULLUP, 32'h0000_005A);
      apb(0, PF_OFS_PULLUP, 0);
      check("pullup rw", rd, 32'h0000_005A);
      apb(1, PF_OFS_FUNC, 32'h0000_00A5);
      apb(0, PF_OFS_FUNC, 0);
      check("func rw", rd, 32'h0000_00A5);
      apb(1, PF_OFS_FUNC, 32'h0000_0000);
      apb(0, 8'h14, 0);
      check("unmapped err", {31'h0, err}, 32'h0000_0001);
      check("unmapped read", rd, 32'h0000_0000);
      $display("test regs done");
   endtask

   task t_pullup;
      apb(1, PF_OFS_PULLUP, 32'h0000_00FF);
      settle;
      check("pullup all in", {24'h0, pullup_on}, 32'h0000_00FF);
      apb(1, PF_OFS_DIR, 32'h0000_000F);
      settle;
      check("pullup outputs off", {24'h0, pullup_on}, 32'h0000_00F0);
      apb(1, PF_OFS_DIR, 32'h0000_0000);
      apb(1, PF_OFS_PULLUP, 32'h0000_0000);
      settle;
      check("pullup cleared", {24'h0, pullup_on}, 32'h0000_0000);
      $display("test pullup done");
   endtask

   task t_gpio;
      @(posedge pclk);
      ext_drv <= 8'h0F;
      ext_val <= 8'h06;
      apb(1, PF_OFS_DATA, 32'h0000_00A5);
      apb(1, PF_OFS_DIR, 32'h0000_00F0);
      settle;
      check("gpio oe", {24'h0, pin_oe}, 32'h0000_00F0);
      check("gpio out", {28'h0, pin_out[7:4]}, 32'h0000_000A);
      apb(0, PF_OFS_DATA, 0);
      check("data read", rd, 32'h0000_00A6);
      $display("test gpio done");
   endtask

   task t_alt_out;
      ext_drv <= 8'h00;
      {pwm_out, tf_high, tf_low, ta_clk} <= 4'hF;
      apb(1, PF_OFS_DATA, 32'h0000_0000);
      apb(1, PF_OFS_DIR, 32'h0000_00FF);
      apb(1, PF_OFS_FUNC, 32'h0000_0017);
      settle;
      check("alt oe", {24'h0, pin_oe}, 32'h0000_00FF);
      check("alt high", {24'h0, pin_out}, 32'h0000_0017);
      @(posedge pclk);
      {pwm_out, tf_high, tf_low, ta_clk} <= 4'h0;
      settle;
      check("alt low", {24'h0, pin_out}, 32'h0000_0000);
      apb(1, PF_OFS_FUNC, 32'h0000_00E8);
      settle;
      check("alt inputs undriven", {24'h0, pin_oe}, 32'h0000_0017);
      apb(1, PF_OFS_DIR, 32'h0000_0000);
      $display("test alt out done");
   endtask

   // software clears the interrupt enables before using the timer event inputs
   task t_events;
      int_three_enable <= 1'b0;
      int_two_enable <= 1'b0;
      ext_drv <= 8'hE8;
      ext_val <= 8'h00;
      tf_sel <= 3'h0;
      tc_sel <= 3'h7;
      apb(1, PF_OFS_EDGE, 32'h0000_0007);
      settle;
      pulses(8'hE8);
      check("rise all", {26'h0, seen}, 32'h0000_003F);
      check("irq masked", {30'h0, irq_seen}, 32'h0000_0000);
      check("capture in", {31'h0, tg_cap}, 32'h0000_0001);
      pulses(8'h00);
      check("fall ignored", {26'h0, seen}, 32'h0000_0000);
      @(posedge pclk);
      tf_sel <= 3'h4;
      tc_sel <= 3'h3;
      pulses(8'hE0);
      check("events gated", {26'h0, seen}, 32'h0000_0039);
      apb(1, PF_OFS_EDGE, 32'h0000_0000);
      pulses(8'h00);
      check("fall sensed", {26'h0, seen}, 32'h0000_0039);
      apb(1, PF_OFS_FUNC, 32'h0000_0000);
      pulses(8'hE0);
      pulses(8'h00);
      check("gpio no events", {26'h0, seen}, 32'h0000_0000);
      $display("test events done");
   endtask

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite} = 3'h0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      {ext_drv, ext_val} = 16'h0000;
      {pwm_out, tf_high, tf_low, ta_clk} = 4'h0;
      tf_sel = 3'h0;
      tc_sel = 3'h0;
      {int_two_enable, int_three_enable} = 2'h3;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_pullup;
      t_gpio;
      t_alt_out;
      t_events;
      close_out;
   end
endmodule
